// >>> rtl/dht_pkg.sv
// constants, bus carrier and state layout of the dual half timer block
package dht_pkg;
    // register byte offsets on the wishbone slave
    localparam logic [7:0] OFS_CFG = 8'h00;
    localparam logic [7:0] OFS_MODE_LOW = 8'h04;
    localparam logic [7:0] OFS_MODE_HIGH = 8'h08;
    localparam logic [7:0] OFS_CTL = 8'h0c;
    localparam logic [7:0] OFS_MASK = 8'h18;
    localparam logic [7:0] OFS_RAW = 8'h1c;
    localparam logic [7:0] OFS_MASKED = 8'h20;
    localparam logic [7:0] OFS_CLEAR = 8'h24;
    localparam logic [7:0] OFS_LOAD_LOW = 8'h28;
    localparam logic [7:0] OFS_LOAD_HIGH = 8'h2c;
    localparam logic [7:0] OFS_MATCH_LOW = 8'h30;
    localparam logic [7:0] OFS_MATCH_HIGH = 8'h34;
    localparam logic [7:0] OFS_PRE_LOW = 8'h38;
    localparam logic [7:0] OFS_PRE_HIGH = 8'h3c;
    localparam logic [7:0] OFS_COUNT_LOW = 8'h48;
    localparam logic [7:0] OFS_COUNT_HIGH = 8'h4c;
    // configuration selector codes
    localparam logic [2:0] CFG_JOIN = 3'h0;
    localparam logic [2:0] CFG_RTC = 3'h1;
    localparam logic [2:0] CFG_SPLIT = 3'h4;
    // half mode field codes
    localparam logic [1:0] MODE_ONESHOT = 2'h1;
    localparam logic [1:0] MODE_PERIODIC = 2'h2;
    // control register bit positions; the high half sits CTL_STRIDE above the low half
    localparam int CTL_W = 14;
    localparam int CTL_EN = 0;
    localparam int CTL_STALL = 1;
    localparam int CTL_RTC_EN = 4;
    localparam int CTL_OTE = 5;
    localparam int CTL_STRIDE = 8;
    // status, mask and clear bit positions
    localparam int IRQ_W = 12;
    localparam int IRQ_TO = 0;
    localparam int IRQ_RTC = 3;
    localparam int IRQ_STRIDE = 8;
    // reset values, and the count loaded on entering clock mode
    localparam logic [15:0] CNT_RST = 16'hffff;
    localparam logic [15:0] LOAD_RST = 16'hffff;
    localparam logic [15:0] MATCH_RST = 16'hffff;
    localparam logic [7:0] PRE_RST = 8'h00;
    localparam logic [31:0] RTC_FIRST = 32'h0000_0001;
    // clock mode divider: input edges per count tick
    localparam int RTC_IN_HZ = 32768;
    localparam int RTC_TICK_HZ = 1;
    localparam int RTC_DIV_DEFAULT = RTC_IN_HZ / RTC_TICK_HZ;

    // classic wishbone request from the master
    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [3:0] sel;
        logic [7:0] adr;
        logic [31:0] dat;
    } dht_wb_req_t;

    // whole state of the block
    typedef struct packed {
        logic [2:0] cfg;
        logic [1:0][1:0] mode;
        logic [CTL_W-1:0] ctl;
        logic [IRQ_W-1:0] imr;
        logic [IRQ_W-1:0] ris;
        logic [1:0][15:0] load;
        logic [1:0][15:0] cnt;
        logic [1:0][15:0] match;
        logic [1:0][7:0] pre;
        logic [1:0][7:0] pcnt;
        logic [15:0] rtc_div;
        logic rtc_q;
        logic ack;
        logic [31:0] dat;
        logic irq;
        logic [1:0] trig;
    } dht_state_t;

    localparam dht_state_t ST_RST = '{
        cfg: CFG_JOIN,
        mode: 4'h0,
        ctl: 14'h0000,
        imr: 12'h000,
        ris: 12'h000,
        load: {LOAD_RST, LOAD_RST},
        cnt: {CNT_RST, CNT_RST},
        match: {MATCH_RST, MATCH_RST},
        pre: {PRE_RST, PRE_RST},
        pcnt: {PRE_RST, PRE_RST},
        rtc_div: 16'h0000,
        rtc_q: 1'b0,
        ack: 1'b0,
        dat: 32'h0000_0000,
        irq: 1'b0,
        trig: 2'h0
    };
endpackage : dht_pkg

// >>> rtl/dht_timer.sv
// dual half timer block: two 16-bit halves, joined 32-bit timer, clock mode, wishbone slave
//
// Notes on behaviour
// - reset: idle, controls cleared, counts/loads 0xFFFF
// - reset clears both prescale values
// - selector 0 joined timer, 1 clock mode
// - selector 0x4 gives two independent halves
// - joined modes act only as one timer
// - joined load write splits low/high words
// - joined count read returns high:low halves
// - only low mode field picks joined behaviour
// - joined count down, reload cycle after zero
// - one-shot stops, clears enable; periodic continues
// - zero sets sticky raw flag, masked if enabled
// - trigger pulse only with trigger enable set
// - load rewrite takes effect next cycle
// - stall enable plus request freezes counter
// - entering clock mode loads count one
// - 32.768 kHz pin input divided to 1 Hz
// - clock count equal match rolls to zero
// - clock match sets raw, masked flag, interrupt
// - clock mode enable overrides stall freezing
// - split halves: 16-bit count, 8-bit prescaler
// - half zero reloads count and prescale
// - half timeout flags, interrupt and trigger
//
// The Wishbone register port and the placing of the registers were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
module dht_timer #(
    parameter int RTC_DIV = dht_pkg::RTC_DIV_DEFAULT
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire dht_pkg::dht_wb_req_t wb_req_i,
    output logic wb_ack_o,
    output logic [31:0] wb_dat_o,
    input wire logic stall_req_i,
    input wire logic capture_pin_zero_i,
    output logic irq_o,
    output logic trig_low_o,
    output logic trig_high_o
);
    import dht_pkg::*;

    // whole state lives in one struct register; next_s is its combinational copy
    dht_state_t s;
    dht_state_t next_s;

    // merges a write into a stored word, honouring byte selects
    function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] sel);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++)
        begin
            if (sel[b])
            begin
                r[8*b +: 8] = nw[8*b +: 8];
            end
        end
        return r;
    endfunction : wmerge

    // last divider value before a tick; the divider is wide enough for the default
    localparam logic [15:0] RTC_LAST = 16'(RTC_DIV - 1);

    // decoded request and configuration, recomputed every cycle
    logic acc;
    logic wr;
    logic [7:0] ofs;
    logic joined;
    logic rtc_mode;
    logic split;
    logic [31:0] cnt32;
    logic [31:0] load32;
    logic [31:0] match32;
    logic [31:0] next_cnt32;
    logic [31:0] wd;
    // one-cycle event and clear masks that feed the sticky status flags
    logic [IRQ_W-1:0] set_ev;
    logic [IRQ_W-1:0] clr_ev;
    logic rtc_edge;
    logic rtc_frozen;
    logic [31:0] rd;

    always_comb
    begin
        // defaults: pulses drop and nothing is flagged unless a branch below says so
        next_s = s;
        next_s.ack = 1'b0;
        next_s.trig = 2'h0;
        set_ev = '0;
        clr_ev = '0;
        // a standing ack blocks taking the same request twice; the master must let go
        acc = wb_req_i.cyc & wb_req_i.stb & ~s.ack;
        wr = acc & wb_req_i.we;
        ofs = {wb_req_i.adr[7:2], 2'b00};
        joined = (s.cfg == CFG_JOIN);
        rtc_mode = (s.cfg == CFG_RTC);
        split = (s.cfg == CFG_SPLIT);
        cnt32 = {s.cnt[1], s.cnt[0]};
        load32 = {s.load[1], s.load[0]};
        match32 = {s.match[1], s.match[0]};
        next_cnt32 = cnt32;
        wd = 32'h0000_0000;
        rd = 32'h0000_0000;
        // capture pin is synchronous; a rising edge is one input clock period
        rtc_edge = capture_pin_zero_i & ~s.rtc_q;
        next_s.rtc_q = capture_pin_zero_i;
        // stall only freezes clock mode while its own enable is clear
        rtc_frozen = stall_req_i & (s.ctl[CTL_STALL] | s.ctl[CTL_STALL + CTL_STRIDE])
            & ~s.ctl[CTL_RTC_EN];

        // joined one-shot/periodic timer, low half's mode only
        // the high half's mode field is never looked at here, so stale values are harmless
        // a load of zero in periodic mode times out on every cycle; software must avoid it
        if (joined && s.ctl[CTL_EN]
            && (s.mode[0] == MODE_ONESHOT || s.mode[0] == MODE_PERIODIC))
        begin
            if (!(stall_req_i && s.ctl[CTL_STALL]))
            begin
                if (cnt32 == 32'h0000_0000)
                begin
                    next_cnt32 = load32;
                    set_ev[IRQ_TO] = 1'b1;
                    next_s.trig[0] = s.ctl[CTL_OTE];
                    if (s.mode[0] == MODE_ONESHOT)
                    begin
                        next_s.ctl[CTL_EN] = 1'b0;
                    end
                end
                else
                begin
                    next_cnt32 = cnt32 - 32'h0000_0001;
                end
            end
            next_s.cnt[1] = next_cnt32[31:16];
            next_s.cnt[0] = next_cnt32[15:0];
        end

        // clock mode: divide pin edges to a one-second tick, count up to the match
        // a pin pulse shorter than one system clock is lost, so the pin must be slow
        // the divider keeps its phase across a stop; only entering clock mode empties it
        if (rtc_mode && s.ctl[CTL_EN] && !rtc_frozen)
        begin
            if (rtc_edge)
            begin
                if (s.rtc_div == RTC_LAST)
                begin
                    next_s.rtc_div = 16'h0000;
                    if (cnt32 == match32)
                    begin
                        next_cnt32 = 32'h0000_0000;
                        set_ev[IRQ_RTC] = 1'b1;
                    end
                    else
                    begin
                        next_cnt32 = cnt32 + 32'h0000_0001;
                    end
                end
                else
                begin
                    next_s.rtc_div = s.rtc_div + 16'h0001;
                end
            end
            next_s.cnt[1] = next_cnt32[31:16];
            next_s.cnt[0] = next_cnt32[15:0];
        end

        // independent halves, each with its own mode, prescaler and stall
        // the prescale count runs first and the half count steps only when it has wrapped,
        // so one step takes prescale plus one clocks and the timeout cycle reloads both
        for (int h = 0; h < 2; h++)
        begin
            if (split && s.ctl[CTL_EN + CTL_STRIDE * h]
                && (s.mode[h] == MODE_ONESHOT || s.mode[h] == MODE_PERIODIC)
                && !(stall_req_i && s.ctl[CTL_STALL + CTL_STRIDE * h]))
            begin
                if (s.pcnt[h] != 8'h00)
                begin
                    next_s.pcnt[h] = s.pcnt[h] - 8'h01;
                end
                else if (s.cnt[h] == 16'h0000)
                begin
                    next_s.cnt[h] = s.load[h];
                    next_s.pcnt[h] = s.pre[h];
                    set_ev[IRQ_TO + IRQ_STRIDE * h] = 1'b1;
                    next_s.trig[h] = s.ctl[CTL_OTE + CTL_STRIDE * h];
                    if (s.mode[h] == MODE_ONESHOT)
                    begin
                        next_s.ctl[CTL_EN + CTL_STRIDE * h] = 1'b0;
                    end
                end
                else
                begin
                    next_s.cnt[h] = s.cnt[h] - 16'h0001;
                    next_s.pcnt[h] = s.pre[h];
                end
            end
        end

        // register writes; a load rewrite overrides the counter's own step
        // byte selects are honoured everywhere; unused upper bits read back as zero
        if (wr)
        begin
            unique case (ofs)
                OFS_CFG:
                begin
                    wd = wmerge({29'h0, s.cfg}, wb_req_i.dat, wb_req_i.sel);
                    next_s.cfg = wd[2:0];
                    // every entry into clock mode restarts the count at one and empties the divider
                    if (wd[2:0] == CFG_RTC && s.cfg != CFG_RTC)
                    begin
                        next_s.cnt[1] = RTC_FIRST[31:16];
                        next_s.cnt[0] = RTC_FIRST[15:0];
                        next_s.rtc_div = 16'h0000;
                    end
                end
                OFS_MODE_LOW:
                begin
                    wd = wmerge({30'h0, s.mode[0]}, wb_req_i.dat, wb_req_i.sel);
                    next_s.mode[0] = wd[1:0];
                end
                OFS_MODE_HIGH:
                begin
                    wd = wmerge({30'h0, s.mode[1]}, wb_req_i.dat, wb_req_i.sel);
                    next_s.mode[1] = wd[1:0];
                end
                OFS_CTL:
                begin
                    wd = wmerge({18'h0, s.ctl}, wb_req_i.dat, wb_req_i.sel);
                    next_s.ctl = wd[CTL_W-1:0];
                end
                OFS_MASK:
                begin
                    wd = wmerge({20'h0, s.imr}, wb_req_i.dat, wb_req_i.sel);
                    next_s.imr = wd[IRQ_W-1:0];
                end
                OFS_CLEAR:
                begin
                    // write one to clear; zero bits leave their flags alone
                    wd = wmerge(32'h0000_0000, wb_req_i.dat, wb_req_i.sel);
                    clr_ev = wd[IRQ_W-1:0];
                end
                OFS_LOAD_LOW:
                begin
                    if (!split)
                    begin
                        wd = wmerge(load32, wb_req_i.dat, wb_req_i.sel);
                        next_s.load[1] = wd[31:16];
                        next_s.load[0] = wd[15:0];
                        if (joined)
                        begin
                            next_s.cnt[1] = wd[31:16];
                            next_s.cnt[0] = wd[15:0];
                        end
                    end
                    else
                    begin
                        wd = wmerge({16'h0, s.load[0]}, wb_req_i.dat, wb_req_i.sel);
                        next_s.load[0] = wd[15:0];
                        next_s.cnt[0] = wd[15:0];
                        next_s.pcnt[0] = s.pre[0];
                    end
                end
                OFS_LOAD_HIGH:
                begin
                    // the high half is reachable on its own only when split
                    if (split)
                    begin
                        wd = wmerge({16'h0, s.load[1]}, wb_req_i.dat, wb_req_i.sel);
                        next_s.load[1] = wd[15:0];
                        next_s.cnt[1] = wd[15:0];
                        next_s.pcnt[1] = s.pre[1];
                    end
                end
                OFS_MATCH_LOW:
                begin
                    if (!split)
                    begin
                        wd = wmerge(match32, wb_req_i.dat, wb_req_i.sel);
                        next_s.match[1] = wd[31:16];
                        next_s.match[0] = wd[15:0];
                    end
                    else
                    begin
                        wd = wmerge({16'h0, s.match[0]}, wb_req_i.dat, wb_req_i.sel);
                        next_s.match[0] = wd[15:0];
                    end
                end
                OFS_MATCH_HIGH:
                begin
                    // joined modes keep the high match word behind the low half's address
                    if (split)
                    begin
                        wd = wmerge({16'h0, s.match[1]}, wb_req_i.dat, wb_req_i.sel);
                        next_s.match[1] = wd[15:0];
                    end
                end
                OFS_PRE_LOW:
                begin
                    wd = wmerge({24'h0, s.pre[0]}, wb_req_i.dat, wb_req_i.sel);
                    next_s.pre[0] = wd[7:0];
                end
                OFS_PRE_HIGH:
                begin
                    wd = wmerge({24'h0, s.pre[1]}, wb_req_i.dat, wb_req_i.sel);
                    next_s.pre[1] = wd[7:0];
                end
                default:
                begin
                    wd = 32'h0000_0000; // read-only or unmapped: write is dropped
                end
            endcase
        end

        // sticky flags: a new event wins over a clear in the same cycle
        // the interrupt follows from the next flags, so it moves on the same edge as they do
        next_s.ris = (s.ris & ~clr_ev) | set_ev;
        next_s.irq = |(next_s.ris & next_s.imr);

        // read mux, registered with the acknowledge
        // joined modes show the pair as one word at the low-half addresses
        // a count read is a snapshot of the cycle in which the request is taken
        unique case (ofs)
            OFS_CFG: rd = {29'h0, s.cfg};
            OFS_MODE_LOW: rd = {30'h0, s.mode[0]};
            OFS_MODE_HIGH: rd = {30'h0, s.mode[1]};
            OFS_CTL: rd = {18'h0, s.ctl};
            OFS_MASK: rd = {20'h0, s.imr};
            OFS_RAW: rd = {20'h0, s.ris};
            OFS_MASKED: rd = {20'h0, s.ris & s.imr};
            OFS_LOAD_LOW: rd = split ? {16'h0, s.load[0]} : load32;
            OFS_LOAD_HIGH: rd = {16'h0, s.load[1]};
            OFS_MATCH_LOW: rd = split ? {16'h0, s.match[0]} : match32;
            OFS_MATCH_HIGH: rd = {16'h0, s.match[1]};
            OFS_PRE_LOW: rd = {24'h0, s.pre[0]};
            OFS_PRE_HIGH: rd = {24'h0, s.pre[1]};
            OFS_COUNT_LOW: rd = split ? {16'h0, s.cnt[0]} : cnt32;
            OFS_COUNT_HIGH: rd = {16'h0, s.cnt[1]};
            default: rd = 32'h0000_0000;
        endcase
        if (acc)
        begin
            next_s.ack = 1'b1;
            next_s.dat = wb_req_i.we ? 32'h0000_0000 : rd;
        end
    end

    // single state register; clock enable low freezes everything
    // reset wins over a low clock enable so the block always starts idle
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            s <= ST_RST;
        end
        else if (ce_i)
        begin
            s <= next_s;
        end
    end

    // outputs straight from the state flops
    // no logic between the flops and the pins, so the outputs cannot glitch
    assign wb_ack_o = s.ack;
    assign wb_dat_o = s.dat;
    assign irq_o = s.irq;
    assign trig_low_o = s.trig[0];
    assign trig_high_o = s.trig[1];
endmodule : dht_timer
`default_nettype wire

// >>> bench/dht_timer_props.sv
// assertion checker for the dual half timer block, bound to its top module
`timescale 1ns/10ps
`default_nettype none
module dht_timer_props #(
    parameter int RTC_DIV = 4
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire dht_pkg::dht_wb_req_t wb_req_i,
    input wire logic wb_ack_o,
    input wire logic [31:0] wb_dat_o,
    input wire logic stall_req_i,
    input wire logic capture_pin_zero_i,
    input wire logic irq_o,
    input wire logic trig_low_o,
    input wire logic trig_high_o
);
    import dht_pkg::*;

    default clocking dc @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    // a bus request is taken only while no ack is standing
    sequence s_take;
        ce_i && wb_req_i.cyc && wb_req_i.stb && !wb_ack_o;
    endsequence
    sequence s_write;
        ce_i && wb_req_i.cyc && wb_req_i.stb && wb_req_i.we && !wb_ack_o;
    endsequence

    // bus answer timing and data
    chk_ack_taken: assert property (s_take |=> wb_ack_o)
        else $error("no ack one cycle after request");
    chk_ack_once: assert property (wb_ack_o && ce_i |=> !wb_ack_o)
        else $error("ack stood longer than one cycle");
    chk_ack_cause: assert property (!wb_req_i.cyc && ce_i |=> !wb_ack_o)
        else $error("ack without request");
    chk_write_data: assert property (s_write |=> wb_dat_o == 32'h0000_0000)
        else $error("write answered with nonzero data");

    // outputs quiet right after reset
    chk_reset_quiet: assert property ($fell(rst_i) |-> !irq_o && !trig_low_o && !trig_high_o && !wb_ack_o)
        else $error("outputs active after reset");

    // triggers are single cycle pulses
    chk_trig_low: assert property (trig_low_o && ce_i |=> !trig_low_o)
        else $error("low trigger longer than one cycle");
    chk_trig_high: assert property (trig_high_o && ce_i |=> !trig_high_o)
        else $error("high trigger longer than one cycle");

    // flags are sticky: only a register write can drop the interrupt
    chk_irq_hold: assert property (irq_o && !(wb_req_i.cyc && wb_req_i.stb && wb_req_i.we) |=> irq_o)
        else $error("interrupt dropped without a write");
endmodule : dht_timer_props

bind dht_timer dht_timer_props #(.RTC_DIV(RTC_DIV)) u_props (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .wb_req_i(wb_req_i),
    .wb_ack_o(wb_ack_o),
    .wb_dat_o(wb_dat_o),
    .stall_req_i(stall_req_i),
    .capture_pin_zero_i(capture_pin_zero_i),
    .irq_o(irq_o),
    .trig_low_o(trig_low_o),
    .trig_high_o(trig_high_o)
);
`default_nettype wire

// >>> bench/dht_timer_test.sv
// self-checking bench for the dual half timer block
`timescale 1ns/10ps
`default_nettype none
module dht_timer_test;
    import dht_pkg::*;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic stall_req_i = 1'b0;
    logic ce_i = 1'b1;
    logic capture_pin_zero_i = 1'b0;
    dht_wb_req_t wb_req_i = '0;
    logic wb_ack_o;
    logic [31:0] wb_dat_o;
    logic irq_o;
    logic trig_low_o;
    logic trig_high_o;
    int errors = 0;
    int checks = 0;
    int n;
    logic [31:0] rd;
    logic [31:0] rd2;

    // a divider of 4 keeps clock mode ticks short
    dht_timer #(.RTC_DIV(4)) dut (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .ce_i(ce_i),
        .wb_req_i(wb_req_i),
        .wb_ack_o(wb_ack_o),
        .wb_dat_o(wb_dat_o),
        .stall_req_i(stall_req_i),
        .capture_pin_zero_i(capture_pin_zero_i),
        .irq_o(irq_o),
        .trig_low_o(trig_low_o),
        .trig_high_o(trig_high_o)
    );

    // 25 MHz system clock
    always #20 clk_i = ~clk_i;

    task end_of_test;
        if (errors == 0 && checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : end_of_test

    task stop_hang;
        errors++;
        $display("unexpected at %0t: wait ran out", $time);
        end_of_test;
    endtask : stop_hang

    task chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp)
        begin
            errors++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask : chk

    // one classic cycle; request held until ack is seen at an edge
    task wb_cycle(input logic wr_en, input logic [7:0] a, input logic [31:0] d);
        int k;
        k = 0;
        @(posedge clk_i);
        wb_req_i <= '{cyc: 1'b1, stb: 1'b1, we: wr_en, sel: 4'hf, adr: a, dat: d};
        do
        begin
            @(posedge clk_i);
            k++;
        end while (wb_ack_o !== 1'b1 && k < 20);
        rd = wb_dat_o;
        wb_req_i <= '0;
        if (wb_ack_o !== 1'b1)
            stop_hang;
    endtask : wb_cycle

    task wr(input logic [7:0] a, input logic [31:0] d);
        wb_cycle(1'b1, a, d);
    endtask : wr

    task rdc(input logic [7:0] a, input logic [31:0] exp);
        wb_cycle(1'b0, a, 32'h0000_0000);
        chk(rd, exp);
    endtask : rdc

    // trigger is a one-cycle pulse, so it is looked at on every edge
    task wait_trig(input logic high, input int lim);
        n = 0;
        do
        begin
            @(posedge clk_i);
            n++;
        end while ((high ? trig_high_o : trig_low_o) !== 1'b1 && n < lim);
        if ((high ? trig_high_o : trig_low_o) !== 1'b1)
            stop_hang;
    endtask : wait_trig

    // slow pin edges, each level held two clocks so none is missed
    task pin_edges(input int k);
        repeat (k)
        begin
            repeat (2) @(posedge clk_i);
            capture_pin_zero_i <= 1'b1;
            repeat (2) @(posedge clk_i);
            capture_pin_zero_i <= 1'b0;
        end
        repeat (4) @(posedge clk_i);
    endtask : pin_edges

    // main sequence
    initial
    begin
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        rdc(OFS_COUNT_LOW, 32'hffff_ffff);
        rdc(OFS_LOAD_LOW, 32'hffff_ffff);
        rdc(OFS_CTL, 32'h0);
        rdc(OFS_CFG, 32'h0);
        rdc(OFS_PRE_LOW, 32'h0);
        rdc(OFS_PRE_HIGH, 32'h0);
        rdc(8'h40, 32'h0);
        // joined one-shot; the high mode field must not matter
        wr(OFS_MODE_HIGH, {30'h0, MODE_PERIODIC});
        wr(OFS_MODE_LOW, {30'h0, MODE_ONESHOT});
        wr(OFS_LOAD_LOW, 32'h0001_0000);
        wr(OFS_LOAD_HIGH, 32'h0000_1234);
        rdc(OFS_COUNT_LOW, 32'h0001_0000);
        wr(OFS_LOAD_LOW, 32'h8);
        wr(OFS_MASK, 32'h1);
        wr(OFS_CTL, 32'h21);
        wait_trig(1'b0, 40);
        chk(32'(n), 32'h9);
        rdc(OFS_RAW, 32'h1);
        rdc(OFS_MASKED, 32'h1);
        chk({31'h0, irq_o}, 32'h1);
        rdc(OFS_CTL, 32'h20);
        rdc(OFS_COUNT_LOW, 32'h8);
        wr(OFS_CLEAR, 32'h1);
        rdc(OFS_RAW, 32'h0);
        chk({31'h0, irq_o}, 32'h0);
        // joined periodic without trigger enable
        wr(OFS_MODE_LOW, {30'h0, MODE_PERIODIC});
        wr(OFS_CTL, 32'h01);
        n = 0;
        repeat (30)
        begin
            @(posedge clk_i);
            n += int'(trig_low_o === 1'b1);
        end
        chk(32'(n), 32'h0);
        rdc(OFS_RAW, 32'h1);
        rdc(OFS_CTL, 32'h01);
        wr(OFS_LOAD_LOW, 32'h40);
        wb_cycle(1'b0, OFS_COUNT_LOW, 32'h0);
        chk({31'h0, rd <= 32'h40 && rd > 32'h30}, 32'h1);
        // stall freezes, release resumes
        wr(OFS_CTL, 32'h03);
        stall_req_i <= 1'b1;
        wb_cycle(1'b0, OFS_COUNT_LOW, 32'h0);
        rd2 = rd;
        wb_cycle(1'b0, OFS_COUNT_LOW, 32'h0);
        chk(rd, rd2);
        stall_req_i <= 1'b0;
        wb_cycle(1'b0, OFS_COUNT_LOW, 32'h0);
        chk({31'h0, rd !== rd2}, 32'h1);
        // clock enable low freezes the count; only three enabled edges lie between the samples
        rd2 = rd;
        ce_i <= 1'b0;
        repeat (10) @(posedge clk_i);
        ce_i <= 1'b1;
        rdc(OFS_COUNT_LOW, rd2 - 32'h0000_0003);
        // stopped counter holds and raises nothing
        wr(OFS_CTL, 32'h0);
        wr(OFS_CLEAR, 32'h1);
        wb_cycle(1'b0, OFS_COUNT_LOW, 32'h0);
        rd2 = rd;
        repeat (100) @(posedge clk_i);
        rdc(OFS_COUNT_LOW, rd2);
        rdc(OFS_RAW, 32'h0);
        // split halves, low one-shot with prescaler, high periodic
        wr(OFS_CFG, {29'h0, CFG_SPLIT});
        wr(OFS_MODE_LOW, {30'h0, MODE_ONESHOT});
        wr(OFS_MODE_HIGH, {30'h0, MODE_PERIODIC});
        wr(OFS_PRE_LOW, 32'h2);
        wr(OFS_LOAD_LOW, 32'h3);
        wr(OFS_LOAD_HIGH, 32'h5);
        wr(OFS_MASK, 32'h100);
        wr(OFS_CTL, 32'h2121);
        wait_trig(1'b0, 40);
        chk(32'(n), 32'hc);
        wait_trig(1'b1, 20);
        chk(32'(n), 32'h6);
        rdc(OFS_CTL, 32'h2120);
        rdc(OFS_RAW, 32'h101);
        rdc(OFS_MASKED, 32'h100);
        chk({31'h0, irq_o}, 32'h1);
        rdc(OFS_COUNT_LOW, 32'h3);
        rdc(OFS_PRE_LOW, 32'h2);
        wr(OFS_CTL, 32'h0);
        wr(OFS_CLEAR, 32'h109);
        // clock mode; stall request must not freeze it
        wr(OFS_CFG, {29'h0, CFG_RTC});
        rdc(OFS_COUNT_LOW, 32'h1);
        wr(OFS_MATCH_LOW, 32'h3);
        wr(OFS_MASK, 32'h8);
        wr(OFS_CTL, 32'h13);
        stall_req_i <= 1'b1;
        pin_edges(8);
        rdc(OFS_COUNT_LOW, 32'h3);
        rdc(OFS_RAW, 32'h0);
        pin_edges(4);
        rdc(OFS_COUNT_LOW, 32'h0);
        rdc(OFS_RAW, 32'h8);
        chk({31'h0, irq_o}, 32'h1);
        wr(OFS_CLEAR, 32'h8);
        rdc(OFS_MASKED, 32'h0);
        end_of_test;
    end
endmodule : dht_timer_test
`default_nettype wire
